// ---- codec_device.sv ----
// Overview of operation
// R1: mic mute gives 80 dB transmit attenuation
// R2: tx codes 0-5 extended, 8-13 normal
// R3: total tx gain 35.5 to 13.5 dB
// R4: rx gain +6 to -6 dB, 1 dB steps
// R5: sidetone -12 to -24 dB, 2 dB steps
// R6: power bit 7 mutes sidetone
// R7: earphone volume 0 to -18 dB, 2 dB
// R8: power bit 3 mutes earphone
// R9: companded word: 8 bits in slots 1-8
// R10: linear word: 15 bits in slots 1-15
// R11: control bits follow the PCM word
// R12: host rounds frequency over 7.8125 Hz
// R13: tone registers at addresses 04 and 05
// R14: high tone 2 dB above low tone
// R15: host puts high group in high register
// R16: nonzero tone values give 255 tones
// R17: tone sum output and buzzer pdm
// R18: mode bit 7 selects A-law or mu-law
// R19: power bit 1 picks earphone amplifier
// R20: undefined codes give most attenuation
`timescale 1ns/1ps
`include "codec_regs.svh"
`default_nettype none
module codec_device #(
   parameter int unsigned TONE_TICK_CYCLES = `TONE_TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   codec_link_if.device link,
   output logic [7:0] power_reg,
   output logic [7:0] mode_reg,
   output logic [7:0] txpga_reg,
   output logic [7:0] rxvol_reg,
   output logic [7:0] high_tone_frequency_reg,
   output logic [7:0] low_tone_frequency_reg,
   output logic signed [7:0] tx_total_gain_hdb,
   output logic signed [7:0] tx_pga_gain_db,
   output logic mic_amp2_extended,
   output logic microphone_silence,
   output logic [7:0] mic_atten_db,
   output logic signed [7:0] rx_pga_gain_db,
   output logic signed [7:0] side_gain_db,
   output logic side_mute,
   output logic signed [7:0] ear_volume_db,
   output logic ear_mute,
   output logic ear_diff_on,
   output logic ear_single_on,
   output logic companded_sel,
   output logic alaw_sel,
   output logic [7:0] compressed_word_bits,
   output logic [14:0] linear_word_bits,
   output logic rx_word_valid,
   output logic signed [7:0] tone_sum,
   output logic buzzer_pdm_out
);
   // ***********************************************
   // gain decoding
   // ***********************************************
   // transmit pga step, normal -10 dB for undefined codes
   function automatic logic signed [7:0] tx_pga_db(input logic [3:0] code);
      if (code <= 4'h5 || (code >= 4'h8 && code <= 4'hd)) begin
         tx_pga_db = 8'(-2 * int'(code[2:0]));
      end else begin
         tx_pga_db = -8'sd10;
      end
   endfunction
   function automatic logic tx_is_extended(input logic [3:0] code);
      tx_is_extended = (code <= 4'h5);
   endfunction
   // linear step decoder with a floor for undefined codes
   function automatic logic signed [7:0] step_db(input logic [3:0] code, input int top,
                                                 input int step, input logic [3:0] last);
      if (code <= last) begin
         step_db = 8'(top - step * int'(code));
      end else begin
         step_db = 8'(top - step * int'(last));
      end
   endfunction

   // ***********************************************
   // link input synchronisers
   // ***********************************************
   logic [1:0] clk_sync, frm_sync, dat_sync;
   logic clk_prev;
   logic clk_rise;
   // two flops per pin, edge found on the second
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_sync <= 2'b00;
         frm_sync <= 2'b00;
         dat_sync <= 2'b00;
         clk_prev <= 1'b0;
      end else begin
         clk_sync <= {clk_sync[0], link.link_clk};
         frm_sync <= {frm_sync[0], link.link_sync};
         dat_sync <= {dat_sync[0], link.link_data};
         clk_prev <= clk_sync[1];
      end
   end
   assign clk_rise = clk_sync[1] & ~clk_prev;

   // ***********************************************
   // frame receiver
   // ***********************************************
   codec_pkg::rx_state_t rx_state_reg;
   logic [30:0] shift_reg;
   logic [5:0] bit_cnt_reg;
   logic [31:0] frame_reg;
   logic frame_done_reg;
   // sync marks slot 1, 32 bits per frame
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_state_reg <= codec_pkg::RX_IDLE;
         shift_reg <= 31'h0;
         bit_cnt_reg <= 6'h0;
         frame_reg <= 32'h0;
         frame_done_reg <= 1'b0;
      end else begin
         frame_done_reg <= 1'b0;
         if (clk_rise) begin
            case (rx_state_reg)
               codec_pkg::RX_IDLE: begin
                  if (frm_sync[1]) begin
                     shift_reg <= {30'h0, dat_sync[1]};
                     bit_cnt_reg <= 6'h1;
                     rx_state_reg <= codec_pkg::RX_FRAME;
                  end
               end
               codec_pkg::RX_FRAME: begin
                  if (frm_sync[1]) begin
                     shift_reg <= {30'h0, dat_sync[1]};
                     bit_cnt_reg <= 6'h1;
                  end else if (bit_cnt_reg == 6'(`FRAME_BITS - 1)) begin
                     frame_reg <= {shift_reg, dat_sync[1]};
                     frame_done_reg <= 1'b1;
                     rx_state_reg <= codec_pkg::RX_IDLE;
                  end else begin
                     shift_reg <= {shift_reg[29:0], dat_sync[1]};
                     bit_cnt_reg <= bit_cnt_reg + 6'h1;
                  end
               end
               default: rx_state_reg <= codec_pkg::RX_IDLE;
            endcase
         end
      end
   end

   // ***********************************************
   // received pcm word
   // ***********************************************
   // slots 1-15 hold linear pcm, slots 1-8 companded pcm, msb first
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         compressed_word_bits <= 8'h0;
         linear_word_bits <= 15'h0;
         rx_word_valid <= 1'b0;
      end else begin
         rx_word_valid <= frame_done_reg;
         if (frame_done_reg) begin
            if (mode_reg[`MODE_COMPAND_BIT]) begin
               compressed_word_bits <= frame_reg[31:24]; // [R9]
            end else begin
               linear_word_bits <= frame_reg[31:17]; // [R10]
            end
         end
      end
   end

   // ***********************************************
   // register file
   // ***********************************************
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   assign wr_addr = frame_reg[15:8]; // control field after pcm [R11]
   assign wr_data = frame_reg[7:0];
   // one write per frame, unknown addresses ignored
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_reg <= `POWER_RST;
         mode_reg <= `MODE_RST;
         txpga_reg <= `TXPGA_RST;
         rxvol_reg <= `RXVOL_RST;
         high_tone_frequency_reg <= `TONE_RST;
         low_tone_frequency_reg <= `TONE_RST;
      end else if (frame_done_reg) begin
         case (wr_addr)
            `REG_POWER: power_reg <= wr_data;
            `REG_MODE: mode_reg <= wr_data;
            `REG_TXPGA: txpga_reg <= wr_data;
            `REG_RXVOL: rxvol_reg <= wr_data;
            `REG_HI_TONE: high_tone_frequency_reg <= wr_data; // [R13]
            `REG_LO_TONE: low_tone_frequency_reg <= wr_data; // [R13]
            default: begin
            end
         endcase
      end
   end

   // ***********************************************
   // gain and path controls
   // ***********************************************
   logic signed [7:0] tx_pga_next;
   assign tx_pga_next = tx_pga_db(txpga_reg[6:3]); // [R2] [R20]
   // decoded settings, registered
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_pga_gain_db <= 8'sh0;
         mic_amp2_extended <= 1'b0;
         tx_total_gain_hdb <= `TX_PREAMP_HDB;
         microphone_silence <= 1'b0;
         mic_atten_db <= 8'h0;
         rx_pga_gain_db <= -8'sd1;
         side_gain_db <= -8'sd12;
         side_mute <= 1'b0;
         ear_volume_db <= 8'sh0;
         ear_mute <= 1'b0;
         ear_diff_on <= 1'b0;
         ear_single_on <= 1'b1;
         companded_sel <= 1'b0;
         alaw_sel <= 1'b0;
      end else begin
         tx_pga_gain_db <= tx_pga_next;
         mic_amp2_extended <= tx_is_extended(txpga_reg[6:3]); // [R2]
         tx_total_gain_hdb <= 8'(`TX_PREAMP_HDB + 8'sd2 * tx_pga_next
            + (tx_is_extended(txpga_reg[6:3]) ? `TX_EXT_HDB : 8'sd0)); // [R3]
         microphone_silence <= power_reg[`PWR_MIC_MUTE_BIT]; // [R1]
         mic_atten_db <= power_reg[`PWR_MIC_MUTE_BIT] ? `MIC_MUTE_ATTEN_DB : 8'h0; // [R1]
         rx_pga_gain_db <= step_db(rxvol_reg[7:4], 6, 1, 4'hc); // [R4] [R20]
         side_gain_db <= step_db({1'b0, txpga_reg[2:0]}, -12, 2, 4'h6); // [R5] [R20]
         side_mute <= power_reg[`PWR_SIDE_MUTE_BIT]; // [R6]
         ear_volume_db <= step_db(rxvol_reg[3:0], 0, 2, 4'h9); // [R7] [R20]
         ear_mute <= power_reg[`PWR_EAR_MUTE_BIT]; // [R8]
         ear_diff_on <= power_reg[`PWR_EAR_DIFF_BIT]; // [R19]
         ear_single_on <= ~power_reg[`PWR_EAR_DIFF_BIT]; // [R19]
         companded_sel <= mode_reg[`MODE_COMPAND_BIT];
         alaw_sel <= mode_reg[`MODE_COMPAND_BIT] & mode_reg[`MODE_ALAW_BIT]; // [R18]
      end
   end

   // ***********************************************
   // tone generator
   // ***********************************************
   // triangle of a 10-bit phase, range -32..31
   function automatic logic signed [7:0] tri_wave(input logic [9:0] ph);
      logic [5:0] t;
      t = ph[9] ? ~ph[8:3] : ph[8:3];
      tri_wave = $signed({2'b00, t}) - 8'sd32;
   endfunction
   logic [12:0] tick_cnt_reg;
   logic [9:0] hi_phase_reg, lo_phase_reg;
   logic signed [7:0] hi_wave, lo_wave;
   logic tone_on;
   assign tone_on = mode_reg[`MODE_TONE_BIT];
   // 8 kHz tick, 10-bit phase gives 7.8125 Hz per step
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_reg <= 13'h0;
         hi_phase_reg <= 10'h0;
         lo_phase_reg <= 10'h0;
      end else if (tick_cnt_reg == 13'(TONE_TICK_CYCLES - 1)) begin
         tick_cnt_reg <= 13'h0;
         hi_phase_reg <= hi_phase_reg + {2'b00, high_tone_frequency_reg}; // [R16]
         lo_phase_reg <= lo_phase_reg + {2'b00, low_tone_frequency_reg}; // [R16]
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 13'h1;
      end
   end
   // high tone scaled by 5/4, about 2 dB louder
   always_comb begin
      lo_wave = (low_tone_frequency_reg != 8'h0) ? tri_wave(lo_phase_reg) : 8'sh0;
      hi_wave = (high_tone_frequency_reg != 8'h0) ? tri_wave(hi_phase_reg) : 8'sh0;
      hi_wave = hi_wave + (hi_wave >>> 2); // [R14]
   end
   // summed dual tone
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tone_sum <= 8'sh0;
      end else begin
         tone_sum <= tone_on ? (hi_wave + lo_wave) : 8'sh0; // [R17]
      end
   end

   // ***********************************************
   // buzzer pdm
   // ***********************************************
   logic [7:0] pdm_acc_reg;
   logic [8:0] pdm_sum;
   assign pdm_sum = {1'b0, pdm_acc_reg} + {1'b0, tone_sum ^ 8'h80};
   // first order modulator, carry is the pulse
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pdm_acc_reg <= 8'h0;
         buzzer_pdm_out <= 1'b0;
      end else begin
         pdm_acc_reg <= pdm_sum[7:0];
         buzzer_pdm_out <= mode_reg[`MODE_BUZZ_BIT] & tone_on & pdm_sum[8]; // [R17]
      end
   end
endmodule
`default_nettype wire

// ---- codec_host.sv ----
`timescale 1ns/1ps
`include "codec_regs.svh"
`default_nettype none
module codec_host (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   codec_link_if.host link
);
   // ***********************************************
   // wishbone registers
   // ***********************************************
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
      for (int i = 0; i < 4; i++) begin
         old[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
      lane_merge = old;
   endfunction
   codec_pkg::tx_state_t state_reg;
   logic [15:0] cmd_reg;
   logic [14:0] pcm_reg;
   logic compand_reg;
   logic wr_hit, rd_hit, start;
   logic [31:0] cmd_new, pcm_new;
   assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign rd_hit = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
   assign cmd_new = lane_merge({16'h0, cmd_reg}, wb_dat_i, wb_sel_i);
   assign pcm_new = lane_merge({17'h0, pcm_reg}, wb_dat_i, wb_sel_i);
   assign start = wr_hit & (wb_adr_i == `WB_CMD) & cmd_new[`CMD_GO_BIT]
      & (state_reg == codec_pkg::TX_IDLE);
   // one-cycle ack, writes to cmd while busy dropped
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         cmd_reg <= {`LINK_NOP_ADDR, 8'h00};
         pcm_reg <= 15'h0;
         compand_reg <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         if (wr_hit) begin
            case (wb_adr_i)
               `WB_CMD: if (state_reg == codec_pkg::TX_IDLE) cmd_reg <= cmd_new[15:0];
               `WB_PCM: pcm_reg <= pcm_new[14:0];
               `WB_CTRL: compand_reg <= wb_sel_i[0] ? wb_dat_i[0] : compand_reg;
               default: begin
               end
            endcase
         end
         if (rd_hit) begin
            case (wb_adr_i)
               `WB_CMD: wb_dat_o <= {16'h0, cmd_reg};
               `WB_PCM: wb_dat_o <= {17'h0, pcm_reg};
               `WB_STATUS: wb_dat_o <= {31'h0, state_reg == codec_pkg::TX_SEND};
               `WB_CTRL: wb_dat_o <= {31'h0, compand_reg};
               default: wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

   // ***********************************************
   // frame sender
   // ***********************************************
   logic [31:0] shift_reg;
   logic [1:0] div_reg;
   logic [5:0] bit_reg;
   logic clk_reg, sync_reg, data_reg;
   logic [15:0] pcm_slots;
   // companded word in slots 1-8, linear in 1-15
   assign pcm_slots = compand_reg ? {pcm_reg[7:0], 8'h00} : {pcm_reg, 1'b0};
   // data changes on falling link edges and as sync rises at frame start, sync only with bit 1
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= codec_pkg::TX_IDLE;
         shift_reg <= 32'h0;
         div_reg <= 2'h0;
         bit_reg <= 6'h0;
         clk_reg <= 1'b0;
         sync_reg <= 1'b0;
         data_reg <= 1'b0;
      end else begin
         case (state_reg)
            codec_pkg::TX_IDLE: begin
               if (start) begin
                  shift_reg <= {pcm_slots, cmd_new[15:0]}; // control after pcm [R11]
                  data_reg <= pcm_slots[15];
                  sync_reg <= 1'b1;
                  div_reg <= 2'h0;
                  bit_reg <= 6'h0;
                  state_reg <= codec_pkg::TX_SEND;
               end
            end
            codec_pkg::TX_SEND: begin
               if (div_reg == 2'(`LINK_HALF_CYCLES - 1)) begin
                  div_reg <= 2'h0;
                  clk_reg <= ~clk_reg;
                  if (clk_reg) begin
                     sync_reg <= 1'b0;
                     if (bit_reg == 6'(`FRAME_BITS - 1)) begin
                        data_reg <= 1'b0;
                        state_reg <= codec_pkg::TX_IDLE;
                     end else begin
                        shift_reg <= {shift_reg[30:0], 1'b0};
                        data_reg <= shift_reg[30];
                        bit_reg <= bit_reg + 6'h1;
                     end
                  end
               end else begin
                  div_reg <= div_reg + 2'h1;
               end
            end
            default: state_reg <= codec_pkg::TX_IDLE;
         endcase
      end
   end
   assign link.link_clk = clk_reg;
   assign link.link_sync = sync_reg;
   assign link.link_data = data_reg;
endmodule
`default_nettype wire

// ---- codec_link_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// link framing and decode checks
// ****
module codec_link_checker (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic link_sync,
   input wire logic link_data,
   input wire logic [7:0] power_reg,
   input wire logic [7:0] mode_reg,
   input wire logic [7:0] mic_atten_db,
   input wire logic microphone_silence,
   input wire logic side_mute,
   input wire logic ear_mute,
   input wire logic ear_diff_on,
   input wire logic ear_single_on,
   input wire logic alaw_sel
);
   // one clock domain
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // decoded controls follow settled registers
   a_mic_mute_atten: assert property (
      $stable(power_reg) |-> mic_atten_db == (power_reg[6] ? 8'd80 : 8'd0)
      && microphone_silence == power_reg[6]) else $error("mic mute attenuation wrong");
   a_side_mute_bit: assert property (
      $stable(power_reg) [*2] |-> side_mute == power_reg[7]) else $error("side mute wrong");
   a_ear_mute_bit: assert property (
      power_reg == $past(power_reg) |-> ear_mute == power_reg[3]) else $error("ear mute wrong");
   a_ear_amp_route: assert property (
      $stable(power_reg) |-> {ear_diff_on, ear_single_on} == {power_reg[1], !power_reg[1]})
      else $error("earphone route wrong");
   a_alaw_select: assert property (
      $stable(mode_reg) |-> alaw_sel == (mode_reg[4] && mode_reg[7]))
      else $error("coding law wrong");
   // link lines move only with the falling link clock, or as sync rises at frame start
   a_sync_on_fall: assert property (
      $fell(link_sync) |-> $fell(link_clk)) else $error("sync fell off clock fall");
   a_data_on_fall: assert property (
      $changed(link_data) |-> $fell(link_clk) || $rose(link_sync))
      else $error("data moved off clock fall");
   a_clk_half_period: assert property (
      $rose(link_clk) |-> link_clk [*4] ##1 !link_clk) else $error("link clock half wrong");
endmodule
`default_nettype wire

// ---- codec_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// serial frame link, host drives all three lines
interface codec_link_if;
   logic link_clk;
   logic link_sync;
   logic link_data;
   modport host (output link_clk, output link_sync, output link_data);
   modport device (input link_clk, input link_sync, input link_data);
endinterface
`default_nettype wire

// ---- codec_pkg.sv ----
package codec_pkg;
   // receiver states
   typedef enum logic [1:0] {
      RX_IDLE = 2'b01,
      RX_FRAME = 2'b10
   } rx_state_t;
   // sender states
   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SEND = 2'b10
   } tx_state_t;
endpackage

// ---- codec_regs.svh ----
`ifndef CODEC_REGS_SVH
`define CODEC_REGS_SVH
// ***********************************************
// device register offsets
// ***********************************************
`define REG_POWER 8'h00
`define REG_MODE 8'h01
`define REG_TXPGA 8'h02
`define REG_RXVOL 8'h03
`define REG_HI_TONE 8'h04
`define REG_LO_TONE 8'h05
`define LINK_NOP_ADDR 8'hff
// ***********************************************
// reset values
// ***********************************************
`define POWER_RST 8'h00
`define MODE_RST 8'h02
`define TXPGA_RST 8'h40
`define RXVOL_RST 8'h70
`define TONE_RST 8'h00
// ***********************************************
// field positions
// ***********************************************
`define PWR_EAR_DIFF_BIT 1
`define PWR_EAR_MUTE_BIT 3
`define PWR_MIC_MUTE_BIT 6
`define PWR_SIDE_MUTE_BIT 7
`define MODE_BUZZ_BIT 3
`define MODE_COMPAND_BIT 4
`define MODE_TONE_BIT 6
`define MODE_ALAW_BIT 7
// ***********************************************
// gain constants
// ***********************************************
`define MIC_MUTE_ATTEN_DB 8'd80
`define TX_PREAMP_HDB 8'sd47
`define TX_EXT_HDB 8'sd24
// ***********************************************
// timing
// ***********************************************
`define SYS_CLK_HZ 50000000
`define SYS_CLK_NS 20
`define TONE_RATE_HZ 8000
`define TONE_TICK_CYCLES (`SYS_CLK_HZ / `TONE_RATE_HZ)
`define LINK_PERIOD_NS 160
`define LINK_HALF_CYCLES (`LINK_PERIOD_NS / (2 * `SYS_CLK_NS))
`define FRAME_BITS 32
// ***********************************************
// host wishbone offsets
// ***********************************************
`define WB_CMD 4'h0
`define WB_PCM 4'h4
`define WB_STATUS 4'h8
`define WB_CTRL 4'hc
`define CMD_GO_BIT 16
`endif

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ****
   // clock, reset, wiring
   // ****
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, comp = 1'b0;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, frame_cap = 32'h0;
   logic [7:0] power_reg, mode_reg, txpga_reg, rxvol_reg, mic_atten_db;
   logic [7:0] high_tone_frequency_reg, low_tone_frequency_reg, compressed_word_bits;
   logic signed [7:0] tx_total_gain_hdb, tx_pga_gain_db, rx_pga_gain_db, side_gain_db;
   logic signed [7:0] ear_volume_db, tone_sum;
   logic wb_ack_o, mic_amp2_extended, microphone_silence, side_mute, ear_mute;
   logic ear_diff_on, ear_single_on, companded_sel, alaw_sel, rx_word_valid, buzzer_pdm_out;
   logic [14:0] linear_word_bits;
   int n_mismatch = 0, checks = 0, cyc = 0, n_words = 0;
   // free-running system clock
   always #10 sys_clk = ~sys_clk;
   codec_link_if link_bus ();
   codec_host codec_host_inst (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link(link_bus));
   codec_device #(.TONE_TICK_CYCLES(8)) codec_device_inst (.sys_clk, .rst_n,
      .link(link_bus), .power_reg, .mode_reg, .txpga_reg, .rxvol_reg,
      .high_tone_frequency_reg, .low_tone_frequency_reg, .tx_total_gain_hdb,
      .tx_pga_gain_db, .mic_amp2_extended, .microphone_silence, .mic_atten_db,
      .rx_pga_gain_db, .side_gain_db, .side_mute, .ear_volume_db, .ear_mute, .ear_diff_on,
      .ear_single_on, .companded_sel, .alaw_sel, .compressed_word_bits, .linear_word_bits,
      .rx_word_valid, .tone_sum, .buzzer_pdm_out);
   codec_link_checker codec_link_checker_inst (.sys_clk, .rst_n,
      .link_clk(link_bus.link_clk), .link_sync(link_bus.link_sync),
      .link_data(link_bus.link_data), .power_reg, .mode_reg, .mic_atten_db,
      .microphone_silence, .side_mute, .ear_mute, .ear_diff_on, .ear_single_on, .alaw_sel);
   // capture each wire bit at the rising link clock
   always @(posedge link_bus.link_clk) frame_cap <= {frame_cap[30:0], link_bus.link_data};
   // count received pcm word pulses
   always @(posedge sys_clk) if (rx_word_valid === 1'b1) n_words <= n_words + 1;
   // ****
   // report and bus tasks
   // ****
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // classic single wishbone cycle, held until ack
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d,
      output logic [31:0] q);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge sys_clk);
   endtask
   // one link frame: pcm, register address, data
   task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic [14:0] pcm);
      logic [31:0] q;
      int n;
      int w;
      n = 0;
      w = n_words;
      wb(1'b1, 4'h4, {17'h0, pcm}, q);
      wb(1'b1, 4'h0, {15'h0, 1'b1, a, d}, q);
      do begin
         wb(1'b0, 4'h8, 32'h0, q);
         n++;
      end while (q[0] !== 1'b0 && n < 400);
      check(q[0], 1'b0);
      repeat (12) @(posedge sys_clk);
      check(n_words - w, 1);
      check(frame_cap, comp ? {pcm[7:0], 8'h00, a, d} : {pcm, 1'b0, a, d});
   endtask
   // ****
   // scenarios
   // ****
   task automatic test_reset();
      check({power_reg, mode_reg, txpga_reg, rxvol_reg}, 32'h0002_4070);
      check({high_tone_frequency_reg, low_tone_frequency_reg}, 32'h0);
      check({tx_total_gain_hdb, rx_pga_gain_db, side_gain_db, ear_volume_db},
         {8'sd47, -8'sd1, -8'sd12, 8'sd0});
   endtask
   task automatic test_tx();
      logic signed [7:0] pga, side;
      logic ext;
      for (int c = 0; c < 16; c++) begin
         ext = c < 6;
         pga = (c < 6) ? 8'(-2 * c) : (c >= 8 && c <= 13) ? 8'(16 - 2 * c) : -8'sd10;
         side = (c % 8 < 7) ? 8'(-12 - 2 * (c % 8)) : -8'sd24;
         frame(8'h02, {1'b0, 4'(c), 3'(c)}, 15'h0);
         check({tx_pga_gain_db, side_gain_db}, {pga, side});
         check({mic_amp2_extended, tx_total_gain_hdb},
            {ext, 8'(47 + (ext ? 24 : 0) + 2 * pga)});
      end
   endtask
   task automatic test_rx();
      for (int c = 0; c < 16; c++) begin
         frame(8'h03, {4'(c), 4'(c)}, 15'h0);
         check({rx_pga_gain_db, ear_volume_db},
            {8'((c <= 12) ? 6 - c : -6), 8'((c <= 9) ? -2 * c : -18)});
      end
   endtask
   task automatic test_power();
      logic [7:0] pw [5] = '{8'h02, 8'h08, 8'h40, 8'h80, 8'h00};
      for (int i = 0; i < 5; i++) begin
         frame(8'h00, pw[i], 15'h0);
         check({microphone_silence, side_mute, ear_mute, ear_diff_on, ear_single_on,
            mic_atten_db}, {pw[i][6], pw[i][7], pw[i][3], pw[i][1], !pw[i][1],
            pw[i][6] ? 8'd80 : 8'd0});
      end
   endtask
   task automatic test_pcm();
      logic [31:0] q;
      frame(8'hff, 8'h00, 15'h5a3c);
      check({companded_sel, alaw_sel, 1'b0, linear_word_bits}, 18'h05a3c);
      frame(8'h01, 8'h90, 15'h0);
      wb(1'b1, 4'hc, 32'h1, q);
      wb(1'b0, 4'hc, 32'h0, q);
      check(q, 32'h1);
      comp = 1'b1;
      frame(8'hff, 8'h00, 15'h7fa5);
      check({companded_sel, alaw_sel, compressed_word_bits}, 10'h3a5);
      frame(8'h01, 8'h10, 15'h0);
      check({companded_sel, alaw_sel}, 2'b10);
      wb(1'b1, 4'hc, 32'h0, q);
      comp = 1'b0;
   endtask
   // same tone value on each register alone, peaks compared
   task automatic test_tone();
      int mx [2];
      int bz;
      bz = 0;
      frame(8'h01, 8'h48, 15'h0);
      for (int i = 0; i < 2; i++) begin
         frame(8'h04, i ? 8'h00 : 8'd155, 15'h0);
         frame(8'h05, i ? 8'd155 : 8'h00, 15'h0);
         mx[i] = 0;
         repeat (3000) begin
            @(posedge sys_clk);
            if (tone_sum > mx[i]) mx[i] = tone_sum;
            bz += buzzer_pdm_out;
         end
      end
      check(mx[0] > mx[1], 1);
      check(bz > 0, 1);
      frame(8'h05, 8'hff, 15'h0);
      check({high_tone_frequency_reg, low_tone_frequency_reg}, 16'h00ff);
      frame(8'h04, 8'($rtoi(1209.0 / 7.8125 + 0.5)), 15'h0);
      frame(8'h05, 8'($rtoi(697.0 / 7.8125 + 0.5)), 15'h0);
      check({high_tone_frequency_reg, low_tone_frequency_reg}, 16'h9b59);
   endtask
   // cycle ceiling against hangs
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   // main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      test_reset();
      test_tx();
      test_rx();
      test_power();
      test_pcm();
      test_tone();
      print_verdict();
   end
endmodule
`default_nettype wire
